/* include/cxs_pkg.sv */
// Constants and types shared by the crosspoint configuration host
package cxs_pkg;

  // ==========================================================
  // Device geometry
  localparam int          NUM_OUTPUTS   = 17;
  localparam logic [4:0]  BCAST_SEL     = 5'h11;
  localparam logic [5:0]  MAX_INPUT     = 6'h20;
  localparam int          SEL_W         = 5;
  localparam int          DATA_W        = 7;
  localparam int          EN_BIT        = 6;

  // ==========================================================
  // Software register map
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam int          CTRL_OP_LSB   = 0;
  localparam int          CTRL_SEL_LSB  = 8;
  localparam int          CTRL_DATA_LSB = 16;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_ERR_BIT  = 1;
  localparam int          STAT_RD_LSB   = 8;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // Command codes written into the op field
  localparam logic [2:0]  OP_PREPROG    = 3'h1;
  localparam logic [2:0]  OP_READBACK   = 3'h2;
  localparam logic [2:0]  OP_UPDATE     = 3'h3;
  localparam logic [2:0]  OP_TRANSP     = 3'h4;
  localparam logic [2:0]  OP_DEV_RESET  = 3'h5;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYNC_STAGES   = 2;
  localparam int T_STROBE_NS   = 15;
  localparam int T_DATA_EN_NS  = 15;
  localparam int T_RESET_NS    = 15;
  localparam int STROBE_CYC    =
    (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC      = SYNC_STAGES +
    (T_DATA_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC     =
    (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_RESET
  } cxs_state_t;

endpackage

/* design/cxs_sync.sv */
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/10ps

module cxs_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             CLK_IN,   // System clock
  input  wire logic             RST_B_IN, // Async reset, active low
  input  wire logic [WIDTH-1:0] D_IN,     // Asynchronous input
  output logic      [WIDTH-1:0] Q_OUT     // Synchronised output
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      stage1 <= '0;
      Q_OUT  <= '0;
    end
    else
    begin
      stage1 <= D_IN;
      Q_OUT  <= stage1;
    end
  end

endmodule

/* design/cxs_host_ctrl.sv */
// Host controller driving the crosspoint switch parallel control pins
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/10ps

module cxs_host_ctrl
  import cxs_pkg::*;
(
  input  wire logic              CLK_IN,                // 10 MHz clock
  input  wire logic              RST_B_IN,              // Async reset
  input  wire logic [7:0]        REG_ADDR_IN,           // Register address
  input  wire logic [31:0]       REG_WDATA_IN,          // Write data
  input  wire logic              REG_WR_IN,             // Write strobe
  input  wire logic              REG_RD_IN,             // Read strobe
  output logic      [31:0]       REG_RDATA_OUT,         // Read data
  output logic                   DEV_RESET_N_OUT,       // Device reset
  output logic                   CHIP_SELECT_N_OUT,     // Chip select
  output logic                   WRITE_STROBE_N_OUT,    // First rank write
  output logic                   READBACK_STROBE_N_OUT, // Readback
  output logic                   TRANSFER_STROBE_N_OUT, // Second rank
  output logic      [SEL_W-1:0]  OUTPUT_SELECT_OUT,     // Output address
  input  wire logic [DATA_W-1:0] CONFIG_DATA_IN,        // Data bus level
  output logic      [DATA_W-1:0] CONFIG_DATA_OUT,       // Data bus drive
  output logic                   CONFIG_DATA_OE_N_OUT   // Drive, active low
);

  cxs_state_t        state;
  cxs_state_t        next_state;
  logic [2:0]        cnt;
  logic [2:0]        next_cnt;
  logic [2:0]        op;
  logic [DATA_W-1:0] rb_data;
  logic [DATA_W-1:0] data_sync;
  logic              err;
  logic              ctrl_wr;
  logic              cmd_ok;
  logic              accept;
  logic [2:0]        w_op;
  logic [SEL_W-1:0]  w_sel;
  logic [DATA_W-1:0] w_data;
  logic [2:0]        cur_op;

  // ==========================================================
  // Pin input synchroniser
  cxs_sync #(.WIDTH(DATA_W)) u_data_sync
  (
    .CLK_IN   (CLK_IN),
    .RST_B_IN (RST_B_IN),
    .D_IN     (CONFIG_DATA_IN),
    .Q_OUT    (data_sync)
  );

  // ==========================================================
  // Command decode and checks
  assign ctrl_wr = REG_WR_IN && (REG_ADDR_IN == CTRL_OFS);
  assign w_op    = REG_WDATA_IN[CTRL_OP_LSB +: 3];
  assign w_sel   = REG_WDATA_IN[CTRL_SEL_LSB +: SEL_W];
  assign w_data  = REG_WDATA_IN[CTRL_DATA_LSB +: DATA_W];

  always_comb
  begin
    cmd_ok = 1'b0;
    case (w_op)
      // Broadcast code is a legal write target, anything above is not
      OP_PREPROG, OP_TRANSP:
        cmd_ok = (w_sel <= BCAST_SEL) &&
                 (w_data[5:0] <= MAX_INPUT);
      OP_READBACK:
        cmd_ok = (w_sel < BCAST_SEL);
      OP_UPDATE, OP_DEV_RESET:
        cmd_ok = 1'b1;
      default:
        cmd_ok = 1'b0;
    endcase
  end

  assign accept = ctrl_wr && cmd_ok && (state == ST_IDLE);
  assign cur_op = accept ? w_op : op;

  // ==========================================================
  // Sequencer
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_IDLE:
        if (accept)
        begin
          if (w_op == OP_DEV_RESET)
          begin
            next_state = ST_RESET;
            next_cnt   = 3'(RESET_CYC - 1);
          end
          else
            next_state = ST_SETUP;
        end
      // Address and data settle a full cycle before any strobe falls
      ST_SETUP:
      begin
        next_state = ST_STROBE;
        next_cnt   = (op == OP_READBACK) ? 3'(READ_CYC - 1)
                                         : 3'(STROBE_CYC - 1);
      end
      ST_STROBE:
        if (cnt == 3'h0)
          next_state = ST_HOLD;
        else
          next_cnt = cnt - 3'h1;
      ST_HOLD:
        next_state = ST_IDLE;
      ST_RESET:
        if (cnt == 3'h0)
          next_state = ST_IDLE;
        else
          next_cnt = cnt - 3'h1;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state <= ST_IDLE;
      cnt   <= 3'h0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Command latch: address and data stay put for the whole cycle
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      op                <= 3'h0;
      OUTPUT_SELECT_OUT <= 5'h00;
      CONFIG_DATA_OUT   <= 7'h00;
    end
    else if (accept)
    begin
      op                <= w_op;
      OUTPUT_SELECT_OUT <= w_sel;
      CONFIG_DATA_OUT   <= w_data;
    end
  end

  // ==========================================================
  // Pin drive from next state; cur_op covers the accept edge
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      DEV_RESET_N_OUT       <= 1'b1;
      CHIP_SELECT_N_OUT     <= 1'b1;
      WRITE_STROBE_N_OUT    <= 1'b1;
      READBACK_STROBE_N_OUT <= 1'b1;
      TRANSFER_STROBE_N_OUT <= 1'b1;
      CONFIG_DATA_OE_N_OUT  <= 1'b1;
    end
    else
    begin
      DEV_RESET_N_OUT       <= (next_state != ST_RESET);
      // Idle leaves the device deselected and the bus released
      CHIP_SELECT_N_OUT     <= (next_state == ST_IDLE ||
                                next_state == ST_RESET);
      WRITE_STROBE_N_OUT    <= !(next_state == ST_STROBE &&
                                 (op == OP_PREPROG ||
                                  op == OP_TRANSP));
      READBACK_STROBE_N_OUT <= !(next_state == ST_STROBE &&
                                 op == OP_READBACK);
      TRANSFER_STROBE_N_OUT <= !(next_state == ST_STROBE &&
                                 (op == OP_UPDATE ||
                                  op == OP_TRANSP));
      CONFIG_DATA_OE_N_OUT  <= !(next_state != ST_IDLE &&
                                 next_state != ST_RESET &&
                                 (cur_op == OP_PREPROG ||
                                  cur_op == OP_TRANSP));
    end
  end

  // ==========================================================
  // Readback capture on the last strobe cycle, after sync latency
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      rb_data <= 7'h00;
    else if (state == ST_STROBE && cnt == 3'h0 && op == OP_READBACK)
      rb_data <= data_sync;
  end

  // Refused command flag; a new refusal wins over the clear
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      err <= 1'b0;
    else if (ctrl_wr && !accept)
      err <= 1'b1;
    else if (REG_WR_IN && REG_ADDR_IN == STAT_OFS &&
             REG_WDATA_IN[STAT_ERR_BIT])
      err <= 1'b0;
  end

  // ==========================================================
  // Register read port
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      REG_RDATA_OUT <= RDATA_RESET;
    else
    begin
      REG_RDATA_OUT <= RDATA_RESET;
      if (REG_RD_IN && REG_ADDR_IN == STAT_OFS)
      begin
        REG_RDATA_OUT[STAT_BUSY_BIT]           <= (state != ST_IDLE);
        REG_RDATA_OUT[STAT_ERR_BIT]            <= err;
        REG_RDATA_OUT[STAT_RD_LSB +: DATA_W]   <= rb_data;
      end
      else if (REG_RD_IN && REG_ADDR_IN == CTRL_OFS)
      begin
        REG_RDATA_OUT[CTRL_OP_LSB +: 3]        <= op;
        REG_RDATA_OUT[CTRL_SEL_LSB +: SEL_W]   <= OUTPUT_SELECT_OUT;
        REG_RDATA_OUT[CTRL_DATA_LSB +: DATA_W] <= CONFIG_DATA_OUT;
      end
    end
  end

  // ==========================================================
  // Checks
  chk_write_read_excl : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     !(!WRITE_STROBE_N_OUT && !READBACK_STROBE_N_OUT))
    else $error("write and readback strobes low together");
  chk_strobe_needs_cs : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     (!WRITE_STROBE_N_OUT || !READBACK_STROBE_N_OUT ||
      !TRANSFER_STROBE_N_OUT) |-> !CHIP_SELECT_N_OUT &&
     $past(!CHIP_SELECT_N_OUT))
    else $error("strobe without settled chip select");
  chk_read_bus_free : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     !READBACK_STROBE_N_OUT |-> CONFIG_DATA_OE_N_OUT)
    else $error("host drives data bus during readback");
  chk_no_bcast_read : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     !READBACK_STROBE_N_OUT |-> OUTPUT_SELECT_OUT < BCAST_SEL)
    else $error("readback at broadcast or reserved address");
  chk_sel_in_range : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     !CHIP_SELECT_N_OUT && (op == OP_PREPROG || op == OP_TRANSP)
     |-> OUTPUT_SELECT_OUT <= BCAST_SEL &&
         CONFIG_DATA_OUT[5:0] <= MAX_INPUT)
    else $error("reserved output or input code used");
  chk_write_setup : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     $fell(WRITE_STROBE_N_OUT) |-> $past(!CONFIG_DATA_OE_N_OUT) &&
     $stable(CONFIG_DATA_OUT) ##1 WRITE_STROBE_N_OUT &&
     !CONFIG_DATA_OE_N_OUT)
    else $error("write data not held around strobe");
  chk_update_pulse : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     $fell(TRANSFER_STROBE_N_OUT) |=> TRANSFER_STROBE_N_OUT ##1
     CHIP_SELECT_N_OUT)
    else $error("transfer strobe pulse or hold wrong");
  chk_read_length : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     $fell(READBACK_STROBE_N_OUT) |-> !READBACK_STROBE_N_OUT[*3]
     ##1 READBACK_STROBE_N_OUT)
    else $error("readback strobe length wrong");
  chk_idle_quiet : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     state == ST_IDLE && $past(state) == ST_IDLE
     |-> CHIP_SELECT_N_OUT && CONFIG_DATA_OE_N_OUT)
    else $error("idle host still selecting device");
  chk_dev_reset : assert property
    (@(posedge CLK_IN) disable iff (!RST_B_IN)
     $fell(DEV_RESET_N_OUT) |-> CHIP_SELECT_N_OUT ##1
     DEV_RESET_N_OUT)
    else $error("device reset pulse wrong");
endmodule

/* tb/cxs_dev_model.sv */
// Behavioural model of the crosspoint switch control latches
`timescale 1ns/10ps

module cxs_dev_model
  import cxs_pkg::*;
#(
  parameter int RD_DELAY_NS = 15
)
(
  input  wire logic              rst_n_in,     // Device reset
  input  wire logic              cs_n_in,      // Chip select
  input  wire logic              we_n_in,      // First rank write
  input  wire logic              re_n_in,      // Readback
  input  wire logic              upd_n_in,     // Transfer
  input  wire logic [SEL_W-1:0]  sel_in,       // Output address
  input  wire logic [DATA_W-1:0] host_d_in,    // Host drive value
  input  wire logic              host_oe_n_in, // Host drives when low
  output logic      [DATA_W-1:0] bus_out       // Resolved data bus
);
  logic [DATA_W-1:0] rank1 [NUM_OUTPUTS];
  logic [DATA_W-1:0] rank2 [NUM_OUTPUTS];
  logic [DATA_W-1:0] last_bus;
  logic              rd_act;
  logic              rd_drv;

  assign rd_act = rst_n_in && !cs_n_in && !re_n_in
                  && we_n_in && upd_n_in;
  assign #(RD_DELAY_NS) rd_drv = rd_act;

  always @*
  begin
    if (!rst_n_in)
      for (int i = 0; i < NUM_OUTPUTS; i++)
        rank2[i][EN_BIT] = 1'b0;
    else if (!cs_n_in && re_n_in)
      for (int i = 0; i < NUM_OUTPUTS; i++)
        if (!we_n_in && (sel_in == BCAST_SEL || sel_in == i))
        begin
          rank1[i] = bus_out;
          if (!upd_n_in)
            rank2[i] = bus_out;
        end
        else if (we_n_in && !upd_n_in)
          rank2[i] = rank1[i];
  end

  // A released bus shows the inverse of its last value, never a hold
  always @*
    if (!host_oe_n_in)
      last_bus = host_d_in;
    else if (rd_drv && rd_act)
      last_bus = rank2[sel_in];

  assign bus_out = !host_oe_n_in ? host_d_in :
                   (rd_drv && rd_act) ? rank2[sel_in] : ~last_bus;
endmodule

/* tb/cxs_host_ctrl_tb.sv */
// Self-checking bench for the crosspoint configuration host
`timescale 1ns/10ps

module cxs_host_ctrl_tb
  import cxs_pkg::*;
;
  logic              CLK_IN = 1'b0;
  logic              RST_B_IN = 1'b0;
  logic [7:0]        REG_ADDR_IN = 8'h00;
  logic [31:0]       REG_WDATA_IN = 32'h0000_0000;
  logic              REG_WR_IN = 1'b0;
  logic              REG_RD_IN = 1'b0;
  logic [31:0]       REG_RDATA_OUT;
  logic              DEV_RESET_N_OUT, CHIP_SELECT_N_OUT, WRITE_STROBE_N_OUT;
  logic              READBACK_STROBE_N_OUT, TRANSFER_STROBE_N_OUT;
  logic              CONFIG_DATA_OE_N_OUT;
  logic [SEL_W-1:0]  OUTPUT_SELECT_OUT;
  logic [DATA_W-1:0] CONFIG_DATA_OUT, bus;
  int                err_total = 0;
  int                compares = 0;

  always #50 CLK_IN = ~CLK_IN;

  cxs_host_ctrl cxs_host_ctrl_inst
  (
    .CLK_IN, .RST_B_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN,
    .REG_RDATA_OUT, .DEV_RESET_N_OUT, .CHIP_SELECT_N_OUT, .WRITE_STROBE_N_OUT,
    .READBACK_STROBE_N_OUT, .TRANSFER_STROBE_N_OUT, .OUTPUT_SELECT_OUT,
    .CONFIG_DATA_IN(bus), .CONFIG_DATA_OUT, .CONFIG_DATA_OE_N_OUT
  );

  // Late readback drive stresses the synchronised capture
  cxs_dev_model #(.RD_DELAY_NS(60)) cxs_dev_model_inst
  (
    .rst_n_in(DEV_RESET_N_OUT), .cs_n_in(CHIP_SELECT_N_OUT),
    .we_n_in(WRITE_STROBE_N_OUT), .re_n_in(READBACK_STROBE_N_OUT),
    .upd_n_in(TRANSFER_STROBE_N_OUT), .sel_in(OUTPUT_SELECT_OUT),
    .host_d_in(CONFIG_DATA_OUT), .host_oe_n_in(CONFIG_DATA_OE_N_OUT),
    .bus_out(bus)
  );

  // ==========================================================
  // Shared tasks
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= d;
    REG_WR_IN <= 1'b1;
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK_IN);
    REG_ADDR_IN <= a;
    REG_RD_IN <= 1'b1;
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b0;
    #1 d = REG_RDATA_OUT;
  endtask

  // Issues a command and polls busy with a bounded count
  task automatic cmd(input logic [2:0] op, input logic [4:0] sel,
                     input logic [6:0] d);
    logic [31:0] s;
    reg_wr(CTRL_OFS, {9'h000, d, 3'h0, sel, 5'h00, op});
    for (int i = 0; i < 20; i++)
    begin
      reg_rd(STAT_OFS, s);
      if (s[STAT_BUSY_BIT] === 1'b0)
        return;
    end
    err_total++;
    $display("MISMATCH busy expected 0 seen 1");
    wrap_up();
  endtask

  task automatic chk_rb(input logic [4:0] sel, input logic [6:0] exp);
    logic [31:0] s;
    cmd(OP_READBACK, sel, 7'h00);
    reg_rd(STAT_OFS, s);
    chk("readback", {25'h0, exp}, {25'h0, s[STAT_RD_LSB +: 7]});
  endtask

  task automatic chk_refused(input logic [2:0] op, input logic [4:0] sel,
                             input logic [6:0] d);
    logic [31:0] s;
    logic        cs_n;
    cs_n = 1'b1;
    reg_wr(CTRL_OFS, {9'h000, d, 3'h0, sel, 5'h00, op});
    repeat (6)
    begin
      @(negedge CLK_IN);
      cs_n &= CHIP_SELECT_N_OUT;
    end
    chk("quiet select", 32'h1, {31'h0, cs_n});
    reg_rd(STAT_OFS, s);
    chk("error set", 32'h1, {31'h0, s[STAT_ERR_BIT]});
    reg_wr(STAT_OFS, 32'h0000_0002);
    reg_rd(STAT_OFS, s);
    chk("error clear", 32'h0, {31'h0, s[STAT_ERR_BIT]});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_idle();
    logic [31:0] s;
    reg_rd(STAT_OFS, s);
    chk("status", 32'h0, s);
    reg_rd(8'h08, s);
    chk("unmapped", 32'h0, s);
    chk("idle select", 32'h1, {31'h0, CHIP_SELECT_N_OUT});
    $display("idle test done");
  endtask

  task automatic t_rows();
    logic [31:0] s;
    cmd(OP_TRANSP, 5'h10, 7'h60);
    reg_rd(CTRL_OFS, s);
    chk("control", {9'h000, 7'h60, 3'h0, 5'h10, 5'h00, OP_TRANSP}, s);
    chk_rb(5'h10, 7'h60);
    cmd(OP_PREPROG, 5'h10, 7'h45);
    chk_rb(5'h10, 7'h60);
    cmd(OP_UPDATE, 5'h00, 7'h00);
    chk_rb(5'h10, 7'h45);
    $display("row test done");
  endtask

  task automatic t_bcast();
    cmd(OP_PREPROG, BCAST_SEL, 7'h47);
    cmd(OP_UPDATE, 5'h00, 7'h00);
    for (int i = 0; i < NUM_OUTPUTS; i++)
      chk("row", 32'h47, {25'h0, cxs_dev_model_inst.rank2[i]});
    chk_rb(5'h00, 7'h47);
    cmd(OP_DEV_RESET, 5'h00, 7'h00);
    for (int i = 0; i < NUM_OUTPUTS; i++)
      chk("enable", 32'h0, {31'h0, cxs_dev_model_inst.rank2[i][EN_BIT]});
    chk_rb(5'h0C, 7'h07);
    $display("broadcast test done");
  endtask

  task automatic t_refuse();
    logic [31:0] s;
    chk_refused(OP_READBACK, BCAST_SEL, 7'h00);
    chk_refused(OP_PREPROG, 5'h12, 7'h00);
    chk_refused(OP_TRANSP, 5'h01, 7'h21);
    chk_refused(3'h7, 5'h00, 7'h00);
    // An update written while a readback runs must be dropped
    reg_wr(CTRL_OFS, {9'h000, 7'h00, 3'h0, 5'h01, 5'h00, OP_READBACK});
    reg_wr(CTRL_OFS, {9'h000, 7'h00, 3'h0, 5'h00, 5'h00, OP_UPDATE});
    repeat (8) @(posedge CLK_IN);
    reg_rd(STAT_OFS, s);
    chk("busy refusal", 32'h2, {30'h0, s[1:0]});
    reg_wr(STAT_OFS, 32'h0000_0002);
    chk_rb(5'h01, 7'h07);
    $display("refusal test done");
  endtask

  initial
  begin
    repeat (10) @(posedge CLK_IN);
    RST_B_IN <= 1'b1;
    t_idle();
    t_rows();
    t_bcast();
    t_refuse();
    wrap_up();
  end
endmodule
